//--- rtl/nvm_command_sequencer.sv
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "nvm_command_sequencer_regs.svh"
module nvm_command_sequencer #(
  parameter int          PAGE_BYTES  = 64,
  parameter logic [15:0] EEPROM_BASE = 16'h1000,
  parameter logic [15:0] EEPROM_END  = 16'h10ff
) (
  // Clock and reset
  input  wire logic             mclk_in,
  input  wire logic             rst_in,
  // Register port
  input  wire logic [3:0]       reg_addr_in,
  input  wire logic [7:0]       reg_wdata_in,
  input  wire logic             reg_wr_in,
  input  wire logic             reg_rd_in,
  input  wire logic             debug_access_in,
  output logic      [7:0]       reg_rdata_out,
  // CPU side
  input  wire logic             self_program_key_in,
  input  wire logic             instr_retire_in,
  output logic                  cpu_halt_out,
  output logic                  irq_out,
  output logic                  boot_lock_out,
  output logic                  app_guard_out,
  // Page buffer load
  input  wire logic             pbuf_wr_in,
  input  wire logic [15:0]      pbuf_addr_in,
  input  wire logic [7:0]       pbuf_data_in,
  // Memory array
  input  wire logic             mem_done_in,
  input  wire logic [$clog2(PAGE_BYTES)-1:0] pbuf_idx_in,
  input  wire logic             eeprom_keep_fuse_in,
  output var nvm_pkg::mem_op_e  mem_op_out,
  output logic                  mem_start_out,
  output logic                  mem_is_eeprom_out,
  output logic                  mem_keep_eeprom_out,
  output logic      [15:0]      mem_addr_out,
  output logic      [15:0]      mem_data_out,
  output logic      [7:0]       pbuf_data_out,
  output logic                  pbuf_marked_out,
  // Sleep
  input  wire logic             sleep_req_in,
  input  wire logic             sleep_idle_mode_in,
  input  wire logic             wake_in,
  output logic                  nvm_asleep_out,
  output logic                  clock_keep_out,
  output logic                  wake_req_out
);
  localparam int IW = $clog2(PAGE_BYTES);

  nvm_pkg::seq_state_e state_reg;
  logic [2:0]  cmd_reg;
  logic [2:0]  unlock_cnt_reg;
  logic [2:0]  clear_cnt_reg;
  logic        erase_write_reg;
  logic        is_ee_reg;
  logic        boot_lock_reg;
  logic        app_guard_reg;
  logic        write_fault_reg;
  logic        irq_en_reg;
  logic        ready_flag_reg;
  logic [15:0] fuse_value_reg;
  logic [15:0] last_addr_reg;
  logic [7:0]  pbuf_mem [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] mark_reg;

  logic       cmd_wr;
  logic       cmd_ok;
  logic [2:0] cmd_new;
  logic       start;
  logic       fuse_refused;
  logic       any_marked;
  logic       flash_busy;
  logic       eeprom_busy;
  logic       ee_done;
  logic       buf_clear;
  logic       addr_is_ee;

  assign cmd_wr  = reg_wr_in && reg_addr_in == `OFS_COMMAND_CONTROL;
  // Debug port writes are not subject to the key guard
  assign cmd_ok  = cmd_wr // [R20]
                   && (unlock_cnt_reg != 3'h0 || debug_access_in);
  assign cmd_new = reg_wdata_in[2:0];
  assign fuse_refused = cmd_ok && cmd_new == `CMD_FUSE_PROGRAM
                        && !debug_access_in;
  assign start = cmd_ok && state_reg == nvm_pkg::st_idle
                 && cmd_new != `CMD_NONE && !fuse_refused; // [R13]
  assign any_marked = |mark_reg;
  assign addr_is_ee = last_addr_reg >= EEPROM_BASE
                      && last_addr_reg <= EEPROM_END;

  always_comb
  begin
    flash_busy  = 1'b0;
    eeprom_busy = 1'b0;
    case (state_reg)
      nvm_pkg::st_erase,
      nvm_pkg::st_write:
      begin
        flash_busy  = !is_ee_reg;
        eeprom_busy = is_ee_reg;
      end
      nvm_pkg::st_full:
      begin
        flash_busy  = 1'b1;
        eeprom_busy = !eeprom_keep_fuse_in;
      end
      nvm_pkg::st_wipe:   eeprom_busy = 1'b1;
      nvm_pkg::st_fuse:   flash_busy  = 1'b1;
      default:            flash_busy  = 1'b0;
    endcase
  end

  // EEPROM page work lets the CPU run; all else halts it
  assign cpu_halt_out = flash_busy // [R2] [R5] [R8]
                        || state_reg == nvm_pkg::st_clear // [R9]
                        || state_reg == nvm_pkg::st_wipe; // [R12]

  assign ee_done = mem_done_in && (((state_reg == nvm_pkg::st_write
                   || (state_reg == nvm_pkg::st_erase && !erase_write_reg))
                   && is_ee_reg) || state_reg == nvm_pkg::st_wipe
                   || (state_reg == nvm_pkg::st_full
                   && !eeprom_keep_fuse_in)); // [R26]

  assign buf_clear = wake_in // [R19]
    || (mem_done_in && (state_reg == nvm_pkg::st_write
        || (state_reg == nvm_pkg::st_erase && !erase_write_reg))) // [R3] [R7]
    || (state_reg == nvm_pkg::st_clear && clear_cnt_reg == 3'h0); // [R9]

  // Key window counts retired instructions
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      unlock_cnt_reg <= 3'h0;
    else if (self_program_key_in)
      unlock_cnt_reg <= `UNLOCK_INSTRUCTIONS; // [R20]
    else if (instr_retire_in && unlock_cnt_reg != 3'h0)
      unlock_cnt_reg <= unlock_cnt_reg - 3'h1;
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      cmd_reg <= 3'h0;
    else if (cmd_ok)
      cmd_reg <= cmd_new; // [R21]
  end

  // Reset returns the sequencer to idle, aborting any operation
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_reg       <= nvm_pkg::st_idle; // [R15]
      mem_op_out      <= nvm_pkg::op_none;
      mem_start_out   <= 1'b0;
      erase_write_reg <= 1'b0;
      is_ee_reg       <= 1'b0;
      clear_cnt_reg   <= 3'h0;
    end
    else
    begin
      mem_start_out <= 1'b0;
      case (state_reg)
        nvm_pkg::st_idle:
          if (start)
          begin
            is_ee_reg       <= addr_is_ee;
            erase_write_reg <= cmd_new == `CMD_ERASE_WRITE;
            case (cmd_new) // [R22]
              `CMD_PAGE_WRITE:
              begin
                state_reg     <= nvm_pkg::st_write; // [R1]
                mem_op_out    <= nvm_pkg::op_write;
                mem_start_out <= 1'b1;
              end
              `CMD_PAGE_ERASE:
                if (any_marked) // [R4]
                begin
                  state_reg     <= nvm_pkg::st_erase; // [R5] [R6]
                  mem_op_out    <= nvm_pkg::op_erase;
                  mem_start_out <= 1'b1;
                end
              `CMD_ERASE_WRITE:
              begin
                state_reg     <= nvm_pkg::st_erase; // [R7]
                mem_op_out    <= nvm_pkg::op_erase;
                mem_start_out <= 1'b1;
              end
              `CMD_BUFFER_CLEAR:
              begin
                state_reg     <= nvm_pkg::st_clear;
                clear_cnt_reg <= `BUFFER_CLEAR_CYCLES - 3'h1; // [R9]
              end
              `CMD_FULL_ERASE:
              begin
                // Locks are deliberately not consulted here
                state_reg     <= nvm_pkg::st_full; // [R10] [R11]
                mem_op_out    <= nvm_pkg::op_full_erase;
                mem_start_out <= 1'b1;
              end
              `CMD_EEPROM_WIPE:
              begin
                state_reg     <= nvm_pkg::st_wipe; // [R12]
                mem_op_out    <= nvm_pkg::op_eeprom_wipe;
                mem_start_out <= 1'b1;
              end
              `CMD_FUSE_PROGRAM:
              begin
                state_reg     <= nvm_pkg::st_fuse; // [R13]
                mem_op_out    <= nvm_pkg::op_fuse_program;
                mem_start_out <= 1'b1;
              end
              default:
                state_reg <= nvm_pkg::st_idle;
            endcase
          end
        nvm_pkg::st_clear:
          if (clear_cnt_reg == 3'h0)
            state_reg <= nvm_pkg::st_idle;
          else
            clear_cnt_reg <= clear_cnt_reg - 3'h1;
        nvm_pkg::st_erase:
          if (mem_done_in && erase_write_reg)
          begin
            state_reg     <= nvm_pkg::st_write; // [R7]
            mem_op_out    <= nvm_pkg::op_write;
            mem_start_out <= 1'b1;
          end
          else if (mem_done_in)
          begin
            state_reg  <= nvm_pkg::st_idle;
            mem_op_out <= nvm_pkg::op_none;
          end
        default:
          if (mem_done_in)
          begin
            state_reg  <= nvm_pkg::st_idle; // [R26]
            mem_op_out <= nvm_pkg::op_none;
          end
      endcase
    end
  end

  assign mem_is_eeprom_out   = is_ee_reg;
  assign mem_keep_eeprom_out = eeprom_keep_fuse_in; // [R10]
  assign mem_addr_out        = last_addr_reg; // [R14]
  assign mem_data_out        = fuse_value_reg;

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      write_fault_reg <= 1'b0;
    else if (fuse_refused)
      write_fault_reg <= 1'b1;
    else if (start)
      write_fault_reg <= 1'b0;
  end

  // Lock bits can only be set; reset alone clears them
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      boot_lock_reg <= 1'b0;
      app_guard_reg <= 1'b0;
    end
    else if (reg_wr_in && reg_addr_in == `OFS_PROTECTION_CONTROL)
    begin
      boot_lock_reg <= boot_lock_reg | reg_wdata_in[`BIT_BOOT_LOCK];
      app_guard_reg <= app_guard_reg | reg_wdata_in[`BIT_APP_GUARD];
    end
  end
  assign boot_lock_out = boot_lock_reg;
  assign app_guard_out = app_guard_reg;

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      irq_en_reg <= 1'b0;
    else if (reg_wr_in && reg_addr_in == `OFS_IRQ_ENABLE)
      irq_en_reg <= reg_wdata_in[`BIT_EEPROM_READY];
  end

  // Completion in the clearing cycle still sets the flag
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      ready_flag_reg <= 1'b0;
    else if (ee_done)
      ready_flag_reg <= 1'b1; // [R16]
    else if (reg_wr_in && reg_addr_in == `OFS_IRQ_FLAGS
             && reg_wdata_in[`BIT_EEPROM_READY])
      ready_flag_reg <= 1'b0; // [R24]
  end
  assign irq_out = ready_flag_reg && irq_en_reg; // [R16]
  assign wake_req_out = irq_out && sleep_idle_mode_in; // [R18]

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      fuse_value_reg <= `RST_WORD;
    else if (reg_wr_in && reg_addr_in == `OFS_FUSE_VALUE_LO)
      fuse_value_reg[7:0] <= reg_wdata_in;
    else if (reg_wr_in && reg_addr_in == `OFS_FUSE_VALUE_HI)
      fuse_value_reg[15:8] <= reg_wdata_in;
  end

  // A buffer load outranks a software write of the address
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      last_addr_reg <= `RST_WORD;
    else if (pbuf_wr_in)
      last_addr_reg <= pbuf_addr_in;
    else if (reg_wr_in && reg_addr_in == `OFS_LAST_ADDRESS_LO)
      last_addr_reg[7:0] <= reg_wdata_in;
    else if (reg_wr_in && reg_addr_in == `OFS_LAST_ADDRESS_HI)
      last_addr_reg[15:8] <= reg_wdata_in;
  end

  // Clearing wins over a load in the same cycle
  for (genvar i = 0; i < PAGE_BYTES; i++)
  begin : g_entry
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
      if (rst_in)
      begin
        pbuf_mem[i] <= 8'hff;
        mark_reg[i] <= 1'b0;
      end
      else if (buf_clear)
      begin
        pbuf_mem[i] <= 8'hff;
        mark_reg[i] <= 1'b0;
      end
      else if (pbuf_wr_in && pbuf_addr_in[IW-1:0] == IW'(i))
      begin
        pbuf_mem[i] <= pbuf_mem[i] & pbuf_data_in; // [R25]
        mark_reg[i] <= 1'b1; // [R6]
      end
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pbuf_data_out   <= 8'hff;
      pbuf_marked_out <= 1'b0;
    end
    else
    begin
      pbuf_data_out   <= pbuf_mem[pbuf_idx_in]; // [R1]
      pbuf_marked_out <= mark_reg[pbuf_idx_in];
    end
  end

  // Ongoing writes hold the clock through any sleep mode
  assign clock_keep_out = sleep_req_in // [R17]
                          && state_reg != nvm_pkg::st_idle;
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      nvm_asleep_out <= 1'b0;
    else
      nvm_asleep_out <= sleep_req_in && state_reg == nvm_pkg::st_idle
                        && !start; // [R17]
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      reg_rdata_out <= 8'h00;
    else if (!reg_rd_in)
      reg_rdata_out <= 8'h00;
    else
      case (reg_addr_in)
        `OFS_COMMAND_CONTROL:    reg_rdata_out <= {5'h00, cmd_reg};
        `OFS_PROTECTION_CONTROL:
          reg_rdata_out <= {6'h00, boot_lock_reg, app_guard_reg};
        `OFS_CONTROLLER_STATUS:
          reg_rdata_out <= {5'h00, write_fault_reg, eeprom_busy,
                            flash_busy}; // [R23]
        `OFS_IRQ_ENABLE:         reg_rdata_out <= {7'h00, irq_en_reg};
        `OFS_IRQ_FLAGS:          reg_rdata_out <= {7'h00, ready_flag_reg};
        `OFS_FUSE_VALUE_LO:      reg_rdata_out <= fuse_value_reg[7:0];
        `OFS_FUSE_VALUE_HI:      reg_rdata_out <= fuse_value_reg[15:8];
        `OFS_LAST_ADDRESS_LO:    reg_rdata_out <= last_addr_reg[7:0];
        `OFS_LAST_ADDRESS_HI:    reg_rdata_out <= last_addr_reg[15:8];
        default:                 reg_rdata_out <= 8'h00;
      endcase
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  property p_clear_len;
    start && cmd_new == `CMD_BUFFER_CLEAR
      |=> cpu_halt_out[*7] ##1 !cpu_halt_out;
  endproperty
  a_clear_len: assert property (p_clear_len) // [R9]
    else $error("buffer clear halt not seven cycles");

  property p_locked_write;
    cmd_wr && unlock_cnt_reg == 3'h0 && !debug_access_in |=> $stable(cmd_reg);
  endproperty
  a_locked_write: assert property (p_locked_write) // [R21]
    else $error("command changed without unlock");

  property p_cpu_fuse;
    fuse_refused |=> state_reg != nvm_pkg::st_fuse && write_fault_reg;
  endproperty
  a_cpu_fuse: assert property (p_cpu_fuse) // [R13]
    else $error("CPU fuse write started");

  property p_empty_erase;
    start && cmd_new == `CMD_PAGE_ERASE && !any_marked
      |=> state_reg == nvm_pkg::st_idle && !mem_start_out;
  endproperty
  a_empty_erase: assert property (p_empty_erase) // [R4]
    else $error("erase ran with empty buffer");

  property p_clear_after;
    state_reg == nvm_pkg::st_write && mem_done_in |=> !any_marked;
  endproperty
  a_clear_after: assert property (p_clear_after) // [R3]
    else $error("buffer not cleared after write");

  property p_flash_halt;
    (state_reg == nvm_pkg::st_write || state_reg == nvm_pkg::st_erase)
      && !is_ee_reg |-> cpu_halt_out;
  endproperty
  a_flash_halt: assert property (p_flash_halt) // [R2]
    else $error("CPU ran during flash write");

  property p_ee_runs;
    state_reg == nvm_pkg::st_erase && is_ee_reg
      |-> !cpu_halt_out && eeprom_busy;
  endproperty
  a_ee_runs: assert property (p_ee_runs) // [R6]
    else $error("CPU halted during EEPROM erase");

  property p_ready_irq;
    ee_done && irq_en_reg |=> irq_out && ready_flag_reg;
  endproperty
  a_ready_irq: assert property (p_ready_irq) // [R16]
    else $error("ready interrupt missing");

  property p_busy_flag;
    $fell(eeprom_busy) |-> ready_flag_reg;
  endproperty
  a_busy_flag: assert property (p_busy_flag) // [R26]
    else $error("EEPROM busy fell without ready flag");

  property p_wake_clear;
    wake_in |=> !any_marked;
  endproperty
  a_wake_clear: assert property (p_wake_clear) // [R19]
    else $error("buffer kept after wake");

  property p_sleep_keep;
    sleep_req_in && (flash_busy || eeprom_busy)
      |-> clock_keep_out ##1 !nvm_asleep_out;
  endproperty
  a_sleep_keep: assert property (p_sleep_keep) // [R17]
    else $error("slept during write");
endmodule
`default_nettype wire

//--- rtl/nvm_command_sequencer_regs.svh
// Function
// R1 - Page write copies buffer into addressed page
// R2 - Flash page write stalls CPU; EEPROM not
// R3 - Buffer cleared after write, erase, erase-write
// R4 - Page erase needs a byte in buffer
// R5 - Flash erase whole page, CPU halted
// R6 - EEPROM erase marked bytes, CPU runs
// R7 - Erase-write erases then programs, buffer kept
// R8 - Erase-write halts CPU on Flash only
// R9 - Buffer clear sets ones, halts seven cycles
// R10 - Chip erase all ones, keep fuse spares EEPROM
// R11 - Chip erase ignores boot lock, write guard
// R12 - EEPROM wipe to ones, CPU halted
// R13 - Fuse write only from debug port
// R14 - Debug loads address, data, then command, reset
// R15 - Reset aborts any ongoing write
// R16 - Ready flag; interrupt while flag and enable
// R17 - Sleep only when idle; keep clock otherwise
// R18 - Ready interrupt wakes from idle sleep only
// R19 - Wake from sleep clears page buffer
// R20 - Command write needs key within four instructions
// R21 - Locked command write leaves register unchanged
// R22 - Command codes zero through seven decoded
// R23 - Status shows Flash and EEPROM busy
// R24 - Ready flag cleared by writing one
// R25 - Buffer write stores AND with old contents
// R26 - Busy spans operation; EEPROM end sets flag
`ifndef NVM_COMMAND_SEQUENCER_REGS_SVH
`define NVM_COMMAND_SEQUENCER_REGS_SVH
`define OFS_COMMAND_CONTROL 4'h0
`define OFS_PROTECTION_CONTROL 4'h1
`define OFS_CONTROLLER_STATUS 4'h2
`define OFS_IRQ_ENABLE 4'h3
`define OFS_IRQ_FLAGS 4'h4
`define OFS_FUSE_VALUE_LO 4'h6
`define OFS_FUSE_VALUE_HI 4'h7
`define OFS_LAST_ADDRESS_LO 4'h8
`define OFS_LAST_ADDRESS_HI 4'h9
`define BIT_APP_GUARD 0
`define BIT_BOOT_LOCK 1
`define BIT_FLASH_BUSY 0
`define BIT_EEPROM_BUSY 1
`define BIT_WRITE_FAULT 2
`define BIT_EEPROM_READY 0
`define RST_BYTE 8'h00
`define RST_WORD 16'h0000
`define CMD_NONE 3'h0
`define CMD_PAGE_WRITE 3'h1
`define CMD_PAGE_ERASE 3'h2
`define CMD_ERASE_WRITE 3'h3
`define CMD_BUFFER_CLEAR 3'h4
`define CMD_FULL_ERASE 3'h5
`define CMD_EEPROM_WIPE 3'h6
`define CMD_FUSE_PROGRAM 3'h7
`define BUFFER_CLEAR_CYCLES 3'h7
`define UNLOCK_INSTRUCTIONS 3'h4
`endif

//--- rtl/nvm_pkg.sv
package nvm_pkg;
  typedef enum logic [2:0] {
    op_none,
    op_write,
    op_erase,
    op_full_erase,
    op_eeprom_wipe,
    op_fuse_program
  } mem_op_e;
  typedef enum {
    st_idle,
    st_clear,
    st_erase,
    st_write,
    st_full,
    st_wipe,
    st_fuse
  } seq_state_e;
endpackage

//--- verification/nvm_array_model.sv
`timescale 1ns/1ps
`default_nettype none
module nvm_array_model (
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  // Sequencer side
  input  wire logic       start_in,
  input  wire logic [7:0] delay_in,
  output logic            done_out
);
  logic [7:0] cnt_reg;
  logic       run_reg;

  // One done pulse per start; a long delay keeps the sequencer busy
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_reg  <= 8'h00;
      run_reg  <= 1'b0;
      done_out <= 1'b0;
    end
    else
    begin
      done_out <= 1'b0;
      if (start_in)
      begin
        run_reg <= 1'b1;
        cnt_reg <= delay_in;
      end
      else if (run_reg && cnt_reg == 8'h00)
      begin
        run_reg  <= 1'b0;
        done_out <= 1'b1;
      end
      else if (run_reg)
        cnt_reg <= cnt_reg - 8'h01;
    end
  end
endmodule
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk, rst, wr, rd, dbg, key, ret, pwr, keep, slp, idlm, wake;
  logic halt, irq, blk, apg, start, iseep, keepo, marked;
  logic asleep, ckeep, wreq, done;
  logic [3:0]  addr;
  logic [5:0]  idx;
  logic [7:0]  wd, rdat, pd, pdat, dly;
  logic [15:0] pa, maddr, mdata;
  nvm_pkg::mem_op_e op;
  int error_cnt, check_count;

  nvm_command_sequencer i_nvm_command_sequencer (
    .mclk_in(mclk), .rst_in(rst), .reg_addr_in(addr),
    .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
    .debug_access_in(dbg), .reg_rdata_out(rdat),
    .self_program_key_in(key), .instr_retire_in(ret),
    .cpu_halt_out(halt), .irq_out(irq), .boot_lock_out(blk),
    .app_guard_out(apg), .pbuf_wr_in(pwr), .pbuf_addr_in(pa),
    .pbuf_data_in(pd), .mem_done_in(done), .pbuf_idx_in(idx),
    .eeprom_keep_fuse_in(keep), .mem_op_out(op),
    .mem_start_out(start), .mem_is_eeprom_out(iseep),
    .mem_keep_eeprom_out(keepo), .mem_addr_out(maddr),
    .mem_data_out(mdata), .pbuf_data_out(pdat),
    .pbuf_marked_out(marked), .sleep_req_in(slp),
    .sleep_idle_mode_in(idlm), .wake_in(wake),
    .nvm_asleep_out(asleep), .clock_keep_out(ckeep),
    .wake_req_out(wreq));

  nvm_array_model i_nvm_array_model (
    .mclk_in(mclk), .rst_in(rst), .start_in(start),
    .delay_in(dly), .done_out(done));

  always #50 mclk = ~mclk;

  task automatic end_of_test;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic chk_op(nvm_pkg::mem_op_e e);
    check_count++;
    if (op !== e)
    begin
      error_cnt++;
      $display("unexpected op exp %0d got %0d", e, op);
    end
  endtask

  // Every task returns one ns after an edge, so no input changes on a clock edge
  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wrr(logic [3:0] a, logic [7:0] d);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    cyc(1);
    wr <= 1'b0;
    cyc(1);
  endtask

  task automatic rdr(logic [3:0] a, logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    cyc(1);
    rd <= 1'b0;
    chk("rdata", {8'h00, e}, {8'h00, rdat});
    cyc(1);
  endtask

  task automatic pld(logic [15:0] a, logic [7:0] d);
    pa <= a;
    pd <= d;
    pwr <= 1'b1;
    cyc(1);
    pwr <= 1'b0;
    cyc(2);
  endtask

  task automatic cmd(logic [2:0] c, logic d, int r);
    key <= !d;
    dbg <= d;
    cyc(1);
    key <= 1'b0;
    if (r > 0)
    begin
      ret <= 1'b1;
      cyc(r);
      ret <= 1'b0;
    end
    // Return just after the taken edge so the start pulse is still seen
    addr <= 4'h0;
    wd <= {5'h00, c};
    wr <= 1'b1;
    cyc(1);
    wr <= 1'b0;
  endtask

  task automatic wait_start(nvm_pkg::mem_op_e e);
    int i;
    for (i = 0; i < 40 && start !== 1'b1; i++)
      cyc(1);
    chk("start", 16'h0001, {15'h0000, start});
    chk_op(e);
    if (start !== 1'b1)
      end_of_test();
  endtask

  task automatic wait_idle;
    int i;
    for (i = 0; i < 200 && op !== nvm_pkg::op_none; i++)
      cyc(1);
    chk_op(nvm_pkg::op_none);
    if (op !== nvm_pkg::op_none)
      end_of_test();
  endtask

  task automatic no_start(int n);
    repeat (n)
    begin
      chk("start", 16'h0000, {15'h0000, start});
      cyc(1);
    end
  endtask

  task automatic t_regs;
    int a;
    for (a = 0; a < 11; a++)
      rdr(a[3:0], 8'h00);
    chk("pbuf", 16'h00ff, {8'h00, pdat});
  endtask

  task automatic t_key_clear;
    int i;
    pld(16'h0003, 8'hf0);
    pld(16'h0003, 8'h3c);
    chk("pbuf", 16'h0030, {8'h00, pdat});
    cmd(3'h4, 1'b0, 3);
    for (i = 0; i < 7; i++)
    begin
      chk("halt", 16'h0001, {15'h0000, halt});
      cyc(1);
    end
    chk("halt", 16'h0000, {15'h0000, halt});
    rdr(4'h0, 8'h04);
    chk("pbuf", 16'h00ff, {8'h00, pdat});
    cmd(3'h1, 1'b0, 6);
    no_start(5);
    rdr(4'h0, 8'h04);
    pld(16'h0003, 8'h11);
    wake <= 1'b1;
    cyc(1);
    wake <= 1'b0;
    cyc(2);
    chk("pbuf", 16'h00ff, {8'h00, pdat});
  endtask

  task automatic t_flash;
    cmd(3'h2, 1'b0, 0);
    no_start(5);
    pld(16'h0043, 8'h00);
    cmd(3'h2, 1'b0, 0);
    wait_start(nvm_pkg::op_erase);
    chk("halt", 16'h0001, {15'h0000, halt});
    wait_idle();
    cyc(1);
    chk("mark", 16'h0000, {15'h0000, marked});
    pld(16'h0003, 8'h55);
    dly <= 8'h05;
    cmd(3'h3, 1'b0, 0);
    wait_start(nvm_pkg::op_erase);
    rdr(4'h2, 8'h01);
    wait_start(nvm_pkg::op_write);
    chk("mark", 16'h0001, {15'h0000, marked});
    chk("halt", 16'h0001, {15'h0000, halt});
    wait_idle();
  endtask

  task automatic t_eeprom;
    wrr(4'h3, 8'h01);
    pld(16'h1005, 8'haa);
    dly <= 8'h14;
    cmd(3'h1, 1'b0, 0);
    wait_start(nvm_pkg::op_write);
    chk("eep", 16'h0001, {15'h0000, iseep});
    chk("halt", 16'h0000, {15'h0000, halt});
    rdr(4'h2, 8'h02);
    slp <= 1'b1;
    cyc(2);
    chk("keep", 16'h0001, {15'h0000, ckeep});
    chk("sleep", 16'h0000, {15'h0000, asleep});
    wait_idle();
    rdr(4'h4, 8'h01);
    chk("irq", 16'h0001, {15'h0000, irq});
    chk("sleep", 16'h0001, {15'h0000, asleep});
    chk("wake", 16'h0000, {15'h0000, wreq});
    idlm <= 1'b1;
    cyc(1);
    chk("wake", 16'h0001, {15'h0000, wreq});
    slp <= 1'b0;
    wrr(4'h4, 8'h01);
    chk("irq", 16'h0000, {15'h0000, irq});
    pld(16'h1006, 8'h00);
    idx <= 6'h06;
    cyc(1);
    chk("mark", 16'h0001, {15'h0000, marked});
    cmd(3'h2, 1'b0, 0);
    wait_start(nvm_pkg::op_erase);
    chk("halt", 16'h0000, {15'h0000, halt});
    wait_idle();
    pld(16'h1007, 8'h00);
    cmd(3'h3, 1'b0, 0);
    wait_start(nvm_pkg::op_erase);
    chk("halt", 16'h0000, {15'h0000, halt});
    wait_idle();
  endtask

  task automatic t_erase_fuse;
    wrr(4'h1, 8'h03);
    rdr(4'h1, 8'h03);
    chk("lock", 16'h0003, {14'h0000, blk, apg});
    keep <= 1'b1;
    cmd(3'h5, 1'b0, 0);
    wait_start(nvm_pkg::op_full_erase);
    chk("keep", 16'h0001, {15'h0000, keepo});
    rdr(4'h2, 8'h01);
    wait_idle();
    cmd(3'h6, 1'b0, 0);
    wait_start(nvm_pkg::op_eeprom_wipe);
    chk("halt", 16'h0001, {15'h0000, halt});
    wait_idle();
    cmd(3'h7, 1'b0, 0);
    no_start(3);
    rdr(4'h2, 8'h04);
    wrr(4'h8, 8'h34);
    wrr(4'h9, 8'h12);
    wrr(4'h6, 8'hcd);
    wrr(4'h7, 8'hab);
    cmd(3'h7, 1'b1, 0);
    wait_start(nvm_pkg::op_fuse_program);
    chk("addr", 16'h1234, maddr);
    chk("data", 16'habcd, mdata);
    wait_idle();
  endtask

  task automatic t_abort;
    dly <= 8'h32;
    pld(16'h0080, 8'h00);
    cmd(3'h1, 1'b0, 0);
    wait_start(nvm_pkg::op_write);
    rst <= 1'b1;
    cyc(1);
    rst <= 1'b0;
    cyc(1);
    chk_op(nvm_pkg::op_none);
    chk("halt", 16'h0000, {15'h0000, halt});
    rdr(4'h2, 8'h00);
  endtask

  initial
  begin
    {mclk, wr, rd, dbg, key, ret, pwr, keep, slp, idlm, wake} = '0;
    rst = 1'b1;
    addr = 4'h0;
    idx = 6'h03;
    wd = 8'h00;
    pd = 8'h00;
    pa = 16'h0000;
    dly = 8'h01;
    error_cnt = 0;
    check_count = 0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    cyc(1);
    t_regs();
    t_key_clear();
    t_flash();
    t_eeprom();
    t_erase_fuse();
    t_abort();
    end_of_test();
  end
endmodule
`default_nettype wire
